/* tb/fcp_host.sv */
`timescale 1ns/10ps
module fcp_host (
   input wire logic i_clk,
   input wire logic i_sdo,
   output logic o_sck,
   output logic o_stb_n,
   output logic o_sdi,
   output logic o_done,
   output logic [15:0] o_rx
);
   // ----------------------------------------------------------------
   // Idle link: clock stands low, strobe high.
   // ----------------------------------------------------------------
   initial begin
      o_sck = 1'b0;
      o_stb_n = 1'b1;
      o_sdi = 1'b0;
      o_done = 1'b0;
      o_rx = '0;
   end

   // Four system clocks per half period give the 400 ns link clock.
   task automatic wait_half();
      repeat (4) @(posedge i_clk);
   endtask

   // A proper frame has 16 rising edges; other counts are asked for
   // only to provoke a framing error.
   task automatic frame(input logic [15:0] w, input int n);
      logic [15:0] r;
      r = '0;
      o_stb_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         o_sdi <= w[4'(15 - i)];
         wait_half();
         r = {r[14:0], i_sdo};
         o_sck <= 1'b1;
         wait_half();
         o_sck <= 1'b0;
      end
      wait_half();
      o_stb_n <= 1'b1;
      // A released data line must not keep showing the last bit.
      o_sdi <= ~o_sdi;
      repeat (6) @(posedge i_clk);
      o_rx <= r;
      o_done <= 1'b1;
      @(posedge i_clk);
      o_done <= 1'b0;
   endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
   import fcp_pkg::*;
   localparam int unsigned PCYC = 100;
   logic clk = 1'b0;
   logic rst_n, sup_ok, overheat, warn, latched, sleep_n;
   logic [7:0] mon;
   logic hsel, hwrite, rd_dph, ser_chk;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic sdo, drive_en, diag, hreadyout, hresp, sck, stb_n, sdi, done;
   logic [1:0] sel;
   logic [3:0] offs;
   logic [15:0] rx;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   int seed = 32'h43c5;

   always #25 clk = ~clk;

   fcp_top #(.P_PULSE_CYC(PCYC)) u_dut (
      .I_CLOCK(clk), .I_ARST_N(rst_n), .I_SCK(sck),
      .I_FRAME_STROBE_N(stb_n), .I_SDI(sdi), .O_SDO(sdo),
      .I_LOGIC_SUPPLY_OK(sup_ok), .I_OVERHEAT(overheat),
      .I_HEAT_WARN(warn), .I_LATCHED_FAULT(latched),
      .I_SLEEP_RESET_N(sleep_n), .I_MON_FAULT(mon),
      .O_DRIVE_EN(drive_en), .O_DIAG(diag),
      .O_PIN_OUTPUT_SELECT(sel), .O_AMP_OFFSET_CODE(offs),
      .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
      .I_HREADY(hreadyout), .O_HRDATA(hrdata),
      .O_HREADYOUT(hreadyout), .O_HRESP(hresp)
   );

   fcp_host u_host (
      .i_clk(clk), .i_sdo(sdo), .o_sck(sck), .o_stb_n(stb_n),
      .o_sdi(sdi), .o_done(done), .o_rx(rx)
   );

   // ----------------------------------------------------------------
   // Reporting
   // ----------------------------------------------------------------
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic print_verdict();
      $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // The run should need about 1600 cycles; this ceiling cuts a hang.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   // Results are matched in order against the notes left by drivers.
   always @(posedge clk) begin
      if (rd_dph) begin
         chk_word(hrdata, exp_q.pop_front());
         chk_pin(hresp, 1'b0);
      end
      if (done && ser_chk) begin
         chk_word({16'h0, rx}, exp_q.pop_front());
      end
      rd_dph <= hsel && htrans[1] && !hwrite && hreadyout;
   end

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      if (!wr) begin
         exp_q.push_back(d);
      end
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wr ? d : 32'h0;
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask

   function automatic logic [15:0] frm(input logic [2:0] a, input logic wr,
                                      input logic [10:0] d);
      frm = {a, wr, d, ~^{a, wr, d}};
   endfunction

   task automatic ser(input logic [15:0] w, input int n, input logic chk,
                      input logic [15:0] e);
      // Set off the edge, so the monitor still sees the flag of the
      // frame that has just ended.
      ser_chk <= chk;
      if (chk) begin
         exp_q.push_back({16'h0, e});
      end
      u_host.frame(w, n);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Any window of one full period holds the same count of high cycles.
   task automatic count_hi(input int exp);
      int hi;
      hi = 0;
      repeat (PCYC) begin
         @(posedge clk);
         hi += int'(diag);
      end
      chk_word(32'(hi), 32'(exp));
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] m;
      logic [7:0] x;
      logic [15:0] e;
      rst_n = 1'b0;
      sup_ok = 1'b1;
      overheat = 1'b0;
      warn = 1'b0;
      latched = 1'b0;
      sleep_n = 1'b1;
      mon = 8'h00;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      rd_dph = 1'b0;
      ser_chk = 1'b0;
      m = 8'($random(seed));
      x = 8'($random(seed));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      tick(4);
      chk_pin(diag, 1'b1);
      chk_pin(drive_en, 1'b1);
      chk_word({30'h0, sel}, 32'h0);
      ahb(1'b0, A_STAT, 32'hC000);
      ahb(1'b0, 8'h10, 32'h0);
      ser(frm(SA_MASK, 1'b1, 11'(m)), 16, 1'b1, 16'hC000);
      ahb(1'b0, A_MASK, 32'(m));
      ahb(1'b0, A_STAT, 32'h0);
      mon <= x;
      tick(5);
      chk_pin(diag, ~|(x & ~m));
      mon <= 8'h00;
      tick(5);
      chk_pin(diag, 1'b1);
      e = {|(x & ~m), 7'h0, x & ~m};
      ahb(1'b0, A_STAT, 32'(e));
      ser(frm(SA_STAT, 1'b0, 11'h0), 16, 1'b1, e);
      ahb(1'b0, A_STAT, 32'h0);
      ahb(1'b1, A_CFG, 32'h4);
      overheat <= 1'b1;
      warn <= 1'b1;
      tick(5);
      chk_pin(drive_en, 1'b0);
      chk_pin(diag, 1'b0);
      overheat <= 1'b0;
      tick(5);
      chk_pin(drive_en, 1'b1);
      chk_pin(diag, 1'b0);
      warn <= 1'b0;
      tick(5);
      chk_pin(diag, 1'b1);
      ahb(1'b1, A_CFG, 32'h0);
      overheat <= 1'b1;
      tick(5);
      chk_pin(drive_en, 1'b1);
      ahb(1'b0, A_STATE, 32'h6);
      overheat <= 1'b0;
      ser(frm(SA_MASK, 1'b1, 11'(~m)), 15, 1'b0, 16'h0);
      ser(frm(SA_MASK, 1'b1, 11'(~m)), 17, 1'b0, 16'h0);
      ser(frm(SA_MASK, 1'b1, 11'(~m)) ^ 16'h1, 16, 1'b0, 16'h0);
      ser(frm(SA_STAT, 1'b0, 11'h0) ^ 16'h1, 16, 1'b0, 16'h0);
      ahb(1'b0, A_MASK, 32'(m));
      ser(frm(SA_MASK, 1'b0, 11'h0), 16, 1'b1, {4'hB, 4'h0, m});
      ahb(1'b0, A_STAT, 32'hB800);
      latched <= 1'b1;
      tick(3);
      latched <= 1'b0;
      tick(5);
      chk_pin(drive_en, 1'b0);
      chk_pin(diag, 1'b0);
      sleep_n <= 1'b0;
      tick(22);
      sleep_n <= 1'b1;
      tick(5);
      chk_pin(drive_en, 1'b1);
      chk_pin(diag, 1'b1);
      ahb(1'b0, A_STAT, 32'hB800);
      ser(frm(SA_CFG, 1'b1, 11'h1), 16, 1'b1, 16'hB800);
      tick(3);
      count_hi(PCYC * FP_HI_OK_PCT / 100);
      warn <= 1'b1;
      tick(5);
      count_hi(PCYC * FP_HI_FLT_PCT / 100);
      warn <= 1'b0;
      ahb(1'b1, A_CFG, 32'h2);
      tick(3);
      chk_pin(diag, 1'b0);
      ahb(1'b1, A_CFG, 32'h5B);
      tick(3);
      chk_pin(diag, 1'b0);
      chk_word({30'h0, sel}, 32'h3);
      chk_word({28'h0, offs}, 32'hB);
      ser(frm(SA_CFG, 1'b0, 11'h0), 16, 1'b1, 16'h805B);
      ahb(1'b1, A_MASK, 32'hFF);
      sup_ok <= 1'b0;
      tick(5);
      chk_pin(drive_en, 1'b0);
      sup_ok <= 1'b1;
      tick(5);
      ahb(1'b0, A_CFG, 32'h0);
      ahb(1'b0, A_MASK, 32'h0);
      ahb(1'b0, A_STAT, 32'hC000);
      chk_pin(diag, 1'b1);
      tick(3);
      print_verdict();
   end
endmodule

/* verilog/fcp_pkg.sv */
package fcp_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int unsigned FP_PERIOD_MS = 100;
   localparam int unsigned FP_CYC = CLK_HZ / 1000 * FP_PERIOD_MS;
   localparam int unsigned FP_HI_FLT_PCT = 20;
   localparam int unsigned FP_HI_OK_PCT = 80;
   localparam int unsigned RST_PULSE_NS = 1000;
   localparam int unsigned RST_CYC =
      (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] RST_LAST = 8'(RST_CYC - 1);

   // ----------------------------------------------------------------
   // Serial frame
   // ----------------------------------------------------------------
   localparam logic [4:0] FRAME_EDGES = 5'h10;
   localparam logic [4:0] RISE_MAX = 5'h11;
   localparam logic [4:0] HDR_LAST = 5'h03;
   localparam logic [3:0] FALL_MAX = 4'hF;
   localparam logic [3:0] TOP_BIT = 4'hF;
   localparam int WR_BIT = 12;
   localparam int DATA_LSB = 1;
   localparam logic [2:0] SA_CFG = 3'h0;
   localparam logic [2:0] SA_MASK = 3'h1;
   localparam logic [2:0] SA_STAT = 3'h2;

   // ----------------------------------------------------------------
   // Register fields
   // ----------------------------------------------------------------
   localparam int CFG_W = 7;
   localparam int CFG_STOP = 2;
   localparam int CFG_AO_LSB = 3;
   localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
   localparam int MASK_W = 8;
   localparam logic [MASK_W-1:0] MASK_RST = 8'h00;
   localparam int ST_POR = 14;
   localparam int ST_OT = 13;
   localparam int ST_SE = 12;
   localparam int ST_TW = 11;
   localparam logic [14:0] STAT_RST = 15'h4000;

   // ----------------------------------------------------------------
   // Bus map
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CFG = 8'h00;
   localparam logic [7:0] A_MASK = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_STATE = 8'h0C;

   // ----------------------------------------------------------------
   // Synchroniser lanes
   // ----------------------------------------------------------------
   localparam int SY_W = 16;
   localparam int SY_SCK = 0;
   localparam int SY_STB = 1;
   localparam int SY_SDI = 2;
   localparam int SY_SUP = 3;
   localparam int SY_OT = 4;
   localparam int SY_TW = 5;
   localparam int SY_LF = 6;
   localparam int SY_SRN = 7;
   localparam int SY_MON = 8;
   localparam logic [SY_W-1:0] SY_INIT = 16'h0082;

   typedef enum logic [1:0] {
      SEL_LEVEL = 2'b00,
      SEL_PULSE = 2'b01,
      SEL_TEMP = 2'b10,
      SEL_OFFS = 2'b11
   } fcp_sel_e;

   typedef struct packed {
      logic sck_d;
      logic stb_d;
      logic [4:0] rises;
      logic [3:0] falls;
      logic [15:0] rx;
      logic [3:0] hdr;
      logic hdr_v;
      logic [CFG_W-1:0] cfg;
      logic [MASK_W-1:0] mask;
      logic [14:0] stat;
      logic latch;
      logic [7:0] rst_cnt;
      logic drive_en;
      logic diag;
      logic sdo;
      logic ahb_wr;
      logic [7:0] ahb_addr;
      logic [31:0] hrdata;
      logic hready;
      logic hresp;
   } fcp_main_s;
endpackage

/* verilog/fcp_pulse.sv */
`timescale 1ns/10ps
module fcp_pulse
   import fcp_pkg::*;
#(
   parameter int unsigned P_CYC = FP_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_run,
   input wire logic i_fault,
   output logic o_pulse
);
   localparam int CW = $clog2(P_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(P_CYC - 1);
   localparam logic [CW-1:0] HI_F = CW'(P_CYC * FP_HI_FLT_PCT / 100);
   localparam logic [CW-1:0] HI_O = CW'(P_CYC * FP_HI_OK_PCT / 100);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic out;
   } fcp_pulse_s;

   fcp_pulse_s s;
   fcp_pulse_s n;

   // ----------------------------------------------------------------
   // Period counter
   // ----------------------------------------------------------------
   // Held at zero while idle so each entry starts a fresh period.
   always_comb begin
      n = s;
      if (!i_run) begin
         n.cnt = '0;
         n.out = 1'b0;
      end else begin
         n.cnt = (s.cnt == LAST) ? '0 : s.cnt + 1'b1;
         n.out = s.cnt < (i_fault ? HI_F : HI_O);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign o_pulse = s.out;
endmodule

/* verilog/fcp_sync.sv */
`timescale 1ns/10ps
module fcp_sync
   import fcp_pkg::*;
#(
   parameter int W = SY_W,
   parameter logic [W-1:0] P_INIT = '0
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fcp_sync_s;

   fcp_sync_s s;
   fcp_sync_s n;

   // The first stage feeds only the second stage of the same lane.
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_lane
         always_comb begin
            n.s1[g] = i_async[g];
            n.s2[g] = s.s1[g];
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s <= {P_INIT, P_INIT};
      end else begin
         s <= n;
      end
   end

   assign o_sync = s.s2;
endmodule

/* verilog/fcp_top.sv */
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module fcp_top
   import fcp_pkg::*;
#(
   parameter int unsigned P_PULSE_CYC = FP_CYC
) (
   input wire logic I_CLOCK,
   input wire logic I_ARST_N,
   input wire logic I_SCK,
   input wire logic I_FRAME_STROBE_N,
   input wire logic I_SDI,
   output logic O_SDO,
   input wire logic I_LOGIC_SUPPLY_OK,
   input wire logic I_OVERHEAT,
   input wire logic I_HEAT_WARN,
   input wire logic I_LATCHED_FAULT,
   input wire logic I_SLEEP_RESET_N,
   input wire logic [7:0] I_MON_FAULT,
   output logic O_DRIVE_EN,
   output logic O_DIAG,
   output logic [1:0] O_PIN_OUTPUT_SELECT,
   output logic [3:0] O_AMP_OFFSET_CODE,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP
);
   localparam fcp_main_s MAIN_RST = '{
      stb_d: 1'b1,
      stat: STAT_RST,
      hready: 1'b1,
      default: '0
   };

   fcp_main_s s;
   fcp_main_s n;
   logic [SY_W-1:0] sy;
   logic pulse;
   logic sup_ok;
   logic ot;
   logic tw;
   logic [7:0] mon;
   logic sck_rise;
   logic sck_fall;
   logic stb_fall;
   logic stb_rise;
   logic frame_ok;
   logic gen_fault;
   logic stat_clr;
   logic ahb_go;
   logic [2:0] rx_addr;
   logic [15:0] stat16;
   logic [15:0] rd_ser;
   logic [15:0] word;
   logic [14:0] sets;
   logic [31:0] rd_ahb;
   fcp_sel_e sel;

   // ----------------------------------------------------------------
   // Input synchronisers and pulse generator
   // ----------------------------------------------------------------
   fcp_sync #(
      .W(SY_W),
      .P_INIT(SY_INIT)
   ) u_sync (
      .i_clk(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .i_async({I_MON_FAULT, I_SLEEP_RESET_N, I_LATCHED_FAULT,
                I_HEAT_WARN, I_OVERHEAT, I_LOGIC_SUPPLY_OK, I_SDI,
                I_FRAME_STROBE_N, I_SCK}),
      .o_sync(sy)
   );

   fcp_pulse #(
      .P_CYC(P_PULSE_CYC)
   ) u_pulse (
      .i_clk(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .i_run(sup_ok && sel == SEL_PULSE),
      .i_fault(gen_fault),
      .o_pulse(pulse)
   );

   // ----------------------------------------------------------------
   // Decodes
   // ----------------------------------------------------------------
   assign sup_ok = sy[SY_SUP];
   assign ot = sy[SY_OT];
   assign tw = sy[SY_TW];
   assign mon = sy[SY_MON +: 8];
   assign sel = fcp_sel_e'(s.cfg[1:0]);
   assign sck_rise = sy[SY_SCK] && !s.sck_d;
   assign sck_fall = !sy[SY_SCK] && s.sck_d;
   assign stb_fall = !sy[SY_STB] && s.stb_d;
   assign stb_rise = sy[SY_STB] && !s.stb_d;
   assign rx_addr = s.rx[15:13];
   assign frame_ok = (s.rises == FRAME_EDGES) && (^s.rx);
   assign stat16 = {|s.stat, s.stat};
   // Overheat and warning are never masked; warning keeps the flag
   // up after overheat has cleared.
   assign gen_fault = ot || tw || (|(mon & ~s.mask)) || s.latch;
   assign ahb_go = I_HSEL && I_HTRANS[1] && I_HREADY;

   always_comb begin
      case (s.hdr[3:1])
         SA_CFG: rd_ser = {9'h000, s.cfg};
         SA_MASK: rd_ser = {8'h00, s.mask};
         SA_STAT: rd_ser = stat16;
         default: rd_ser = 16'h0000;
      endcase
   end

   always_comb begin
      case (I_HADDR[7:0])
         A_CFG: rd_ahb = {25'h0000000, s.cfg};
         A_MASK: rd_ahb = {24'h000000, s.mask};
         A_STAT: rd_ahb = {16'h0000, stat16};
         A_STATE: rd_ahb = {29'h00000000, s.drive_en, gen_fault, s.latch};
         default: rd_ahb = 32'h00000000;
      endcase
   end

   // Reads replace the tail of the frame with the addressed register;
   // writes keep the status word throughout.
   assign word = (s.hdr_v && !s.hdr[0]) ? {stat16[15:12], rd_ser[11:0]}
                                       : stat16;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n = s;
      stat_clr = 1'b0;
      sets = '0;
      sets[ST_OT] = ot;
      sets[ST_TW] = tw;
      sets[7:0] = mon & ~s.mask;
      n.sck_d = sy[SY_SCK];
      n.stb_d = sy[SY_STB];
      n.hready = 1'b1;
      n.hresp = 1'b0;

      // Bus writes land first so that a serial write wins a tie.
      n.ahb_wr = ahb_go && I_HWRITE;
      n.ahb_addr = I_HADDR[7:0];
      n.hrdata = (ahb_go && !I_HWRITE) ? rd_ahb : 32'h00000000;
      if (s.ahb_wr) begin
         case (s.ahb_addr)
            A_CFG: n.cfg = I_HWDATA[CFG_W-1:0];
            A_MASK: n.mask = I_HWDATA[MASK_W-1:0];
            default: n.cfg = s.cfg;
         endcase
      end

      if (stb_fall) begin
         n.rises = '0;
         n.falls = '0;
         n.hdr_v = 1'b0;
      end else if (!sy[SY_STB]) begin
         if (sck_rise) begin
            n.rx = {s.rx[14:0], sy[SY_SDI]};
            if (s.rises != RISE_MAX) begin
               n.rises = s.rises + 5'h01;
            end
            if (s.rises == HDR_LAST) begin
               n.hdr_v = 1'b1;
               n.hdr = {s.rx[2:0], sy[SY_SDI]};
            end
         end
         if (sck_fall && s.falls != FALL_MAX) begin
            n.falls = s.falls + 4'h1;
         end
      end

      if (stb_rise) begin
         if (frame_ok) begin
            if (s.rx[WR_BIT]) begin
               case (rx_addr)
                  SA_CFG: n.cfg = s.rx[DATA_LSB +: CFG_W];
                  SA_MASK: n.mask = s.rx[DATA_LSB +: MASK_W];
                  default: n.cfg = n.cfg;
               endcase
            end
            stat_clr = s.rx[WR_BIT] || rx_addr == SA_STAT;
         end else begin
            sets[ST_SE] = 1'b1;
         end
      end

      // New events win over a same-cycle reset of the bits.
      n.stat = (stat_clr ? 15'h0000 : s.stat) | sets;

      // A long enough low on the sleep reset clears the latched
      // disable only; status bits are left alone.
      n.rst_cnt = sy[SY_SRN] ? 8'h00
                : (s.rst_cnt == RST_LAST) ? s.rst_cnt : s.rst_cnt + 8'h01;
      n.latch = sy[SY_LF] ||
                (s.latch && !(s.rst_cnt == RST_LAST && !sy[SY_SRN]));
      n.drive_en = !s.latch && !(ot && s.cfg[CFG_STOP]);

      case (sel)
         SEL_LEVEL: n.diag = !gen_fault;
         SEL_PULSE: n.diag = pulse;
         default: n.diag = 1'b0;
      endcase

      n.sdo = !sy[SY_STB] && word[TOP_BIT - n.falls];

      // Supply loss is not subject to any mask bit and holds every
      // register at its power-on value until it recovers.
      if (!sup_ok) begin
         n = MAIN_RST;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         s <= MAIN_RST;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign O_SDO = s.sdo;
   assign O_DRIVE_EN = s.drive_en;
   assign O_DIAG = s.diag;
   assign O_PIN_OUTPUT_SELECT = s.cfg[1:0];
   assign O_AMP_OFFSET_CODE = s.cfg[CFG_AO_LSB +: 4];
   assign O_HRDATA = s.hrdata;
   assign O_HREADYOUT = s.hready;
   assign O_HRESP = s.hresp;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_ARST_N);

   sequence s_bad_end;
      stb_rise && !frame_ok && sup_ok;
   endsequence

   sequence s_still_up;
      ##1 sup_ok;
   endsequence

   a_pwr_lockout: assert property (
      !sup_ok |=> !O_DRIVE_EN && s.stat == STAT_RST && s.cfg == CFG_RST)
      else $error("outputs not held off in supply lockout");

   a_por_flags: assert property (
      $rose(sup_ok) |-> stat16[15] && s.stat[ST_POR] && s.mask == MASK_RST)
      else $error("startup flags missing after lockout");

   a_stop_on_ot: assert property (
      sup_ok && ot && s.cfg[CFG_STOP] |=> !O_DRIVE_EN)
      else $error("drive stayed on during overheat stop");

   a_no_stop_ot: assert property (
      sup_ok && ot && !s.cfg[CFG_STOP] && !s.latch |=> O_DRIVE_EN)
      else $error("drive disabled with stop enable clear");

   a_level_low: assert property (
      sup_ok && sel == SEL_LEVEL && gen_fault |=> !O_DIAG)
      else $error("level flag not low on fault");

   a_level_high: assert property (
      sup_ok && sel == SEL_LEVEL && !gen_fault |=> O_DIAG)
      else $error("level flag not high without fault");

   a_frame_err: assert property (
      s_bad_end |=> s.stat[ST_SE])
      else $error("bad frame did not set serial error");

   a_err_regs: assert property (
      s_bad_end ##0 !s.ahb_wr ##0 s_still_up
      |-> $stable(s.cfg) && $stable(s.mask))
      else $error("bad frame changed a register");

   a_latch_keep: assert property (
      sup_ok && !stat_clr ##0 s_still_up
      |-> (s.stat & $past(s.stat)) == $past(s.stat))
      else $error("latched fault bit lost");

   a_sdo_summary: assert property (
      stb_fall && sup_ok |=> O_SDO == $past(stat16[15]))
      else $error("summary bit not on serial output");

   a_sleep_clear: assert property (
      s.rst_cnt == RST_LAST && !sy[SY_SRN] && !sy[SY_LF] ##0 s_still_up
      |-> !s.latch)
      else $error("sleep reset pulse did not clear latch");

   a_bus_okay: assert property (
      O_HREADYOUT && !O_HRESP)
      else $error("bus slave not ready or not okay");
endmodule
